// ### core/tws_core.v
// Function
// - drive data-out bit when drive enabled
// - drive enable sets data pin direction
// - clock-out bit drives clock pin
// - data-in bit sampled on clock edge
// - mode bit picks master or slave
// - interface reset bit holds slave idle
// - direction flag shows slave transmitting
// - byte done flag set per slave data byte, not by the address byte
// - data register access clears done flag
// - own address register defaults 55h
// - data register: transmit write, receive read
// - spi select bit low enables interface
// - control register at E8h, bit-addressable, reset zero
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.vh"
module tws_core (
    input wire clk_sys_in,
    input wire rst_b_in,
    input wire ce_in,
    input wire [7:0] sfr_addr_in,
    input wire [7:0] sfr_wdata_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    input wire sfr_bit_wr_in,
    input wire [2:0] sfr_bit_sel_in,
    input wire sfr_bit_val_in,
    output reg [7:0] sfr_rdata_out,
    output wire irq_out,
    input wire spi_select_bit_in,
    input wire serial_data_pin_in,
    output wire serial_data_pin_out,
    output wire serial_data_pin_oe_out,
    input wire serial_clock_pin_in,
    output wire serial_clock_pin_out,
    output wire serial_clock_pin_oe_out
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_RX = 3'h3;
    localparam ST_RACK = 3'h4;
    localparam ST_TX = 3'h5;
    localparam ST_TACK = 3'h6;

    reg [7:0] two_wire_control;
    reg [7:0] own_slave_address;
    reg [7:0] bus_data_buffer;
    reg [7:0] tx_shift;
    reg [7:0] rx_shift;
    reg [3:0] bit_cnt;
    reg [2:0] state;
    reg sda_s1, sda_s2, sda_d;
    reg scl_s1, scl_s2, scl_d;
    reg sda_low;
    wire master = two_wire_control[`TWS_B_MODE];
    wire enabled = ~spi_select_bit_in;
    wire scl_rise = scl_s2 & ~scl_d;
    wire scl_fall = ~scl_s2 & scl_d;
    wire start_c = scl_s2 & sda_d & ~sda_s2;
    wire stop_c = scl_s2 & ~sda_d & sda_s2;
    wire data_acc = (sfr_wr_in | sfr_rd_in) && sfr_addr_in == `TWS_ADDR_DATA;
    wire slv_run = enabled & ~master & ~two_wire_control[`TWS_B_IRST];
    reg byte_evt;

    function hit;
        input [7:0] a;
        input [7:0] r;
        begin
            hit = (a == r);
        end
    endfunction

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
        end else if (ce_in) begin
            sda_s1 <= serial_data_pin_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            scl_s1 <= serial_clock_pin_in;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
        end
    end

    wire m_sda_low = two_wire_control[`TWS_B_DEN] & ~two_wire_control[`TWS_B_DOUT];
    assign serial_data_pin_out = 1'b0;
    assign serial_data_pin_oe_out = enabled & (master ? m_sda_low : sda_low);
    assign serial_clock_pin_out = 1'b0;
    assign serial_clock_pin_oe_out = enabled & master & ~two_wire_control[`TWS_B_COUT];
    assign irq_out = two_wire_control[`TWS_B_DONE] & ~master;

    // slave engine
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
            sda_low <= 1'b0;
            byte_evt <= 1'b0;
        end else if (ce_in) begin
            byte_evt <= 1'b0;
            if (!slv_run) begin
                state <= ST_IDLE;
                sda_low <= 1'b0;
                bit_cnt <= 4'h0;
            end else if (start_c) begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_low <= 1'b0;
            end else if (stop_c) begin
                state <= ST_IDLE;
                sda_low <= 1'b0;
            end else begin
                case (state)
                    ST_ADDR, ST_RX: begin
                        if (scl_rise) begin
                            rx_shift <= {rx_shift[6:0], sda_s2};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (scl_fall && bit_cnt == `TWS_BITS_ACK) begin
                            bit_cnt <= 4'h0;
                            if (state == ST_RX) begin
                                sda_low <= 1'b1;
                                state <= ST_RACK;
                            end else if (hit({1'b0, rx_shift[7:1]},
                                             {1'b0, own_slave_address[6:0]})) begin
                                sda_low <= 1'b1;
                                state <= ST_AACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK, ST_RACK: begin
                        if (scl_fall) begin
                            if (state == ST_AACK && rx_shift[0]) begin
                                tx_shift <= {bus_data_buffer[6:0], 1'b0};
                                sda_low <= ~bus_data_buffer[7];
                                state <= ST_TX;
                            end else begin
                                sda_low <= 1'b0;
                                state <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise)
                            bit_cnt <= bit_cnt + 4'h1;
                        if (scl_fall) begin
                            if (bit_cnt == `TWS_BITS_ACK) begin
                                sda_low <= 1'b0;
                                bit_cnt <= 4'h0;
                                state <= ST_TACK;
                            end else begin
                                sda_low <= ~tx_shift[7];
                                tx_shift <= {tx_shift[6:0], 1'b0};
                            end
                        end
                    end
                    ST_TACK: begin
                        if (scl_rise) begin
                            byte_evt <= 1'b1;
                            if (sda_s2) begin
                                state <= ST_IDLE;
                            end else begin
                                tx_shift <= {bus_data_buffer[6:0], 1'b0};
                                state <= ST_AACK;
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
                if (state == ST_RX && scl_fall && bit_cnt == `TWS_BITS_ACK)
                    byte_evt <= 1'b1;
            end
        end
    end

    // ST_AACK after TACK needs tx reload on fall; handled via rx_shift[0] hold
    wire [7:0] wbit_mask = 8'h01 << sfr_bit_sel_in;

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            two_wire_control <= `TWS_RST_CTRL;
            own_slave_address <= `TWS_RST_OWN;
            bus_data_buffer <= `TWS_RST_DATA;
        end else if (ce_in) begin
            if (sfr_wr_in && hit(sfr_addr_in, `TWS_ADDR_CTRL))
                two_wire_control <= sfr_wdata_in;
            if (sfr_bit_wr_in && hit(sfr_addr_in, `TWS_ADDR_CTRL))
                two_wire_control <= sfr_bit_val_in ? (two_wire_control | wbit_mask)
                                                   : (two_wire_control & ~wbit_mask);
            if (sfr_wr_in && hit(sfr_addr_in, `TWS_ADDR_OWN))
                own_slave_address <= sfr_wdata_in;
            if (sfr_wr_in && hit(sfr_addr_in, `TWS_ADDR_DATA))
                bus_data_buffer <= sfr_wdata_in;
            else if (slv_run && state == ST_RX && scl_fall && bit_cnt == `TWS_BITS_ACK)
                bus_data_buffer <= rx_shift;
            if (master && !two_wire_control[`TWS_B_DEN] && scl_rise)
                two_wire_control[`TWS_B_DIN] <= sda_s2;
            if (!master) begin
                if (state == ST_TX || state == ST_TACK)
                    two_wire_control[`TWS_B_DIR] <= 1'b1;
                else if (state == ST_RX || state == ST_RACK)
                    two_wire_control[`TWS_B_DIR] <= 1'b0;
                if (byte_evt)
                    two_wire_control[`TWS_B_DONE] <= 1'b1;
                else if (data_acc)
                    two_wire_control[`TWS_B_DONE] <= 1'b0;
            end else if (data_acc) begin
                two_wire_control[`TWS_B_DONE] <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in)
            sfr_rdata_out <= 8'h00;
        else if (ce_in) begin
            case (sfr_addr_in)
                `TWS_ADDR_CTRL: sfr_rdata_out <= two_wire_control;
                `TWS_ADDR_OWN: sfr_rdata_out <= own_slave_address;
                `TWS_ADDR_DATA: sfr_rdata_out <= bus_data_buffer;
                default: sfr_rdata_out <= 8'h00;
            endcase
        end
    end
endmodule // tws_core
`default_nettype wire

// ### core/tws_defines.vh
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH
`define TWS_ADDR_CTRL 8'hE8
`define TWS_ADDR_DATA 8'h9A
`define TWS_ADDR_OWN 8'h9B
`define TWS_RST_CTRL 8'h00
`define TWS_RST_DATA 8'h00
`define TWS_RST_OWN 8'h55
`define TWS_B_DOUT 7
`define TWS_B_DEN 6
`define TWS_B_COUT 5
`define TWS_B_DIN 4
`define TWS_B_MODE 3
`define TWS_B_IRST 2
`define TWS_B_DIR 1
`define TWS_B_DONE 0
`define TWS_BITS_LAST 4'h7
`define TWS_BITS_ACK 4'h8
`endif

// ### test/test_tws_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_tws_core;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, bw = 1'b0, bv = 1'b0;
    logic spi = 1'b0, ack;
    logic [2:0] bs = 3'h0;
    logic [7:0] ad = 8'h00, wd = 8'h00, q;
    wire logic [7:0] rdata;
    wire logic irq, sdo, sdoe, sco, scoe, psl, pdl, sda, scl;
    int fails = 0, tests_run = 0;
    assign sda = !(sdoe || pdl);
    assign scl = !(scoe || psl);
    always #20 clk = !clk;
    tws_core dut_u (.clk_sys_in(clk), .rst_b_in(rst_b), .ce_in(ce), .sfr_addr_in(ad),
        .sfr_wdata_in(wd), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_bit_wr_in(bw),
        .sfr_bit_sel_in(bs), .sfr_bit_val_in(bv), .sfr_rdata_out(rdata), .irq_out(irq),
        .spi_select_bit_in(spi), .serial_data_pin_in(sda), .serial_data_pin_out(sdo),
        .serial_data_pin_oe_out(sdoe), .serial_clock_pin_in(scl),
        .serial_clock_pin_out(sco), .serial_clock_pin_oe_out(scoe));
    tws_partner pm_u (.sda_in(sda), .scl_low_out(psl), .sda_low_out(pdl));
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        ad <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic bit_wr(input logic [2:0] s, input logic v);
        @(posedge clk);
        ad <= 8'he8;
        bs <= s;
        bv <= v;
        bw <= 1'b1;
        @(posedge clk);
        bw <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        ad <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd_reg(a, v);
        check(n, v, e);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk("ctrl", 8'he8, 8'h00);
        rd_chk("own", 8'h9b, 8'h55);
        rd_chk("data", 8'h9a, 8'h00);
        rd_chk("unmapped", 8'h10, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr_reg(8'he8, {i[2:0], 5'h08});
            check("data_oe", sdoe, i[1] && !i[2]);
            check("clock_oe", scoe, !i[0]);
            check("pin_lvl", {sdo, sco}, 2'b00);
        end
        for (int v = 0; v < 2; v++) begin
            pm_u.hold_sda(v[0]);
            wr_reg(8'he8, 8'h08);
            wr_reg(8'he8, 8'h28);
            repeat (4) @(posedge clk);
            rd_reg(8'he8, q);
            check("data_in", q[4], v[0]);
        end
        bit_wr(3'h5, 1'b0);
        check("bit_clock", scoe, 1'b1);
        bit_wr(3'h5, 1'b1);
        check("bit_set", scoe, 1'b0);
        @(posedge clk) spi <= 1'b1;
        wr_reg(8'he8, 8'h48);
        check("spi_data", sdoe, 1'b0);
        check("spi_clock", scoe, 1'b0);
        @(posedge clk) spi <= 1'b0;
        $display("test master done");
        wr_reg(8'he8, 8'h00);
        wr_reg(8'h9b, 8'h2a);
        rd_chk("own_wr", 8'h9b, 8'h2a);
        @(posedge clk) ce <= 1'b0;
        wr_reg(8'h9b, 8'h11);
        @(posedge clk) ce <= 1'b1;
        rd_chk("ce_hold", 8'h9b, 8'h2a);
        pm_u.start();
        pm_u.xfer(8'h54, 1'b1, q, ack);
        check("addr_ack", ack, 1'b0);
        pm_u.xfer(8'hc3, 1'b1, q, ack);
        check("data_ack", ack, 1'b0);
        repeat (4) @(posedge clk);
        rd_reg(8'he8, q);
        check("done", q[0], 1'b1);
        check("dir_rx", q[1], 1'b0);
        check("irq", irq, 1'b1);
        rd_chk("rx_byte", 8'h9a, 8'hc3);
        rd_reg(8'he8, q);
        check("cleared", q[0], 1'b0);
        pm_u.stop();
        wr_reg(8'h9a, 8'h96);
        pm_u.start();
        pm_u.xfer(8'h55, 1'b1, q, ack);
        check("rd_ack", ack, 1'b0);
        // slave turns to transmit a few cycles after the ack clock falls
        repeat (4) @(posedge clk);
        rd_reg(8'he8, q);
        check("dir_tx", q[1], 1'b1);
        pm_u.xfer(8'hff, 1'b1, q, ack);
        check("tx_byte", q, 8'h96);
        pm_u.stop();
        rd_reg(8'he8, q);
        check("tx_done", q[0], 1'b1);
        $display("test slave done");
        for (int k = 0; k < 3; k++) begin
            wr_reg(8'he8, k == 1 ? 8'h04 : 8'h00);
            pm_u.start();
            pm_u.xfer(k == 0 ? 8'h56 : 8'h54, 1'b1, q, ack);
            check("nak", ack, k < 2);
            pm_u.stop();
        end
        $display("test address done");
        summarize();
    end
endmodule // test_tws_core
`default_nettype wire

// ### test/tws_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tws_chk (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic irq_out,
    input wire logic spi_select_bit_in,
    input wire logic serial_data_pin_out,
    input wire logic serial_data_pin_oe_out,
    input wire logic serial_clock_pin_oe_out,
    input wire logic serial_clock_pin_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    wire logic cw = sfr_wr_in && ce_in && sfr_addr_in == 8'he8;
    wire logic m = cw && sfr_wdata_in[3] && !spi_select_bit_in;
    wire logic da = ce_in && (sfr_wr_in || sfr_rd_in) && sfr_addr_in == 8'h9a;
    wire logic um = sfr_addr_in != 8'he8 && sfr_addr_in != 8'h9a && sfr_addr_in != 8'h9b;
    a_data_drive: assert property (m && sfr_wdata_in[6] && !sfr_wdata_in[7]
        |=> spi_select_bit_in || serial_data_pin_oe_out) else $error("data not driven");
    a_data_release: assert property (m && !sfr_wdata_in[6]
        |=> spi_select_bit_in || !serial_data_pin_oe_out) else $error("data not released");
    a_clock_follow: assert property (m
        |=> spi_select_bit_in || serial_clock_pin_oe_out == !$past(sfr_wdata_in[5]))
        else $error("clock pin wrong");
    a_slave_clock_free: assert property (cw && !sfr_wdata_in[3]
        |=> !serial_clock_pin_oe_out) else $error("slave drives clock");
    a_spi_owns_pins: assert property (spi_select_bit_in
        |-> !serial_data_pin_oe_out && !serial_clock_pin_oe_out) else $error("pins not freed");
    a_open_drain: assert property (!serial_data_pin_out) else $error("pin driven high");
    a_clock_drain: assert property (!serial_clock_pin_out) else $error("clock driven high");
    a_access_clear: assert property (da |=> !irq_out) else $error("flag not cleared");
    a_unmapped_zero: assert property (ce_in && sfr_rd_in && um
        |=> sfr_rdata_out == 8'h00) else $error("unmapped read not zero");
    a_reset_idle: assert property ($rose(rst_b_in)
        |-> !serial_data_pin_oe_out && !serial_clock_pin_oe_out && !irq_out)
        else $error("not idle after reset");
    c_master: cover property (m);
    c_slave: cover property (cw && !sfr_wdata_in[3]);
    c_flag: cover property ($rose(irq_out));
endmodule // tws_chk
bind tws_core tws_chk chk_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .irq_out(irq_out),
    .spi_select_bit_in(spi_select_bit_in), .serial_data_pin_out(serial_data_pin_out),
    .serial_data_pin_oe_out(serial_data_pin_oe_out),
    .serial_clock_pin_oe_out(serial_clock_pin_oe_out),
    .serial_clock_pin_out(serial_clock_pin_out));
`default_nettype wire

// ### test/tws_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tws_partner (
    input wire logic sda_in,
    output logic scl_low_out,
    output logic sda_low_out
);
    localparam int QTR = 80;
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end
    task automatic hold_sda(input logic v);
        sda_low_out = !v;
    endtask
    task automatic start();
        sda_low_out = 1'b1;
        #(2 * QTR) scl_low_out = 1'b1;
    endtask
    task automatic stop();
        #QTR sda_low_out = 1'b1;
        #QTR scl_low_out = 1'b0;
        #(2 * QTR) sda_low_out = 1'b0;
        #(2 * QTR);
    endtask
    // data moves only while clock low
    task automatic clk_bit(input logic b, output logic r);
        #QTR sda_low_out = !b;
        #QTR scl_low_out = 1'b0;
        #(2 * QTR) r = sda_in;
        scl_low_out = 1'b1;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
        output logic a);
        for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
        clk_bit(ak, a);
    endtask
endmodule // tws_partner
`default_nettype wire
